//--- hw/or_move_load_instr_exec.sv
// execution unit for the or, file move, pointer load and
// register-to-register move instructions, with apb register access
// assumes an apb master on clk_sys_in and a synchronous active-low reset
//
// How it works
// - or literal into accumulator, low byte literal
// - or accumulator with addressed file register
// - destination bit picks accumulator or file
// - access bit picks access bank or bank select
// - extended mode, low addresses index pointer two
// - or and file move set flags; pointer loads and register move do not
// - file move copies file to chosen destination
// - eight-bit file operand covers whole bank
// - pointer load takes 12-bit literal, selector 0-2
// - pointer load is two words, second fixed prefix
// - register move copies anywhere to anywhere
`timescale 1ns/100ps
module or_move_load_instr_exec #(
  parameter int ADDR_W = 12
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out
);

  logic [31:0]          prdata_q;
  logic                 pready_q;
  logic                 pslverr_q;
  logic                 wait_q;
  logic                 ext_en_q;
  logic [7:0]           acc_q;
  logic [3:0]           bank_q;
  logic [3:0]           ptr_hi_q [3];
  logic [7:0]           ptr_lo_q [3];
  logic                 zero_q;
  logic                 neg_q;
  logic                 illegal_q;
  logic [ADDR_W-1:0]    mem_addr_q;
  logic [31:0]          instr_q;
  logic                 cycle_q;
  logic                 word2_ok_q;
  logic [7:0]           result_q;
  exec_pkg::ex_state_t  ex_state_q;
  exec_pkg::decode_t    dec_q;
  exec_pkg::mem_req_t   mem_req;
  logic [7:0]           mem_rd_data;
  logic [ADDR_W-1:0]    eff_addr;
  logic [31:0]          rd_val;
  logic                 refuse;
  logic                 busy;
  logic                 access;
  logic                 apb_wr;
  logic                 mem_rd_req;
  logic                 q4_first;
  logic                 q4_second;
  logic                 file_op;

  function automatic exec_pkg::decode_t decode_word(input logic [15:0] w);
    exec_pkg::decode_t d;
    d.kind   = exec_pkg::OP_NONE;
    d.dest   = w[9];
    d.access = w[8];
    d.file   = w[7:0];
    d.sel    = w[5:4];
    d.lit_hi = w[3:0];
    d.src    = w[11:0];
    if (w[15:8] == exec_pkg::IOR_LIT_OP) begin
      d.kind = exec_pkg::OP_IOR_LIT;
    end else if (w[15:10] == exec_pkg::IOR_FILE_OP) begin
      d.kind = exec_pkg::OP_IOR_FILE;
    end else if (w[15:10] == exec_pkg::FILE_MOVE_OP) begin
      d.kind = exec_pkg::OP_FILE_MOVE;
    end else if (w[15:6] == exec_pkg::PTR_LOAD_OP &&
                 w[5:4] != exec_pkg::PTR_SEL_BAD) begin
      d.kind = exec_pkg::OP_PTR_LOAD;
    end else if (w[15:12] == exec_pkg::REG_MOVE_OP) begin
      d.kind = exec_pkg::OP_REG_MOVE;
    end
    return d;
  endfunction

  assign prdata_out  = prdata_q;
  assign pready_out  = pready_q;
  assign pslverr_out = pslverr_q;

  assign busy    = ex_state_q != exec_pkg::EX_IDLE;
  assign access  = psel_in && penable_in && !pready_q;
  // a write commits at the edge where the master sees pready high
  assign apb_wr  = psel_in && penable_in && pready_q && pwrite_in &&
                   !pslverr_q;
  assign mem_rd_req = access && !wait_q && !pwrite_in && !busy &&
                      paddr_in == exec_pkg::MEM_DATA_OFS;
  assign q4_first  = ex_state_q == exec_pkg::EX_Q4 && !cycle_q;
  assign q4_second = ex_state_q == exec_pkg::EX_Q4 && cycle_q;
  assign file_op   = dec_q.kind == exec_pkg::OP_IOR_FILE ||
                     dec_q.kind == exec_pkg::OP_FILE_MOVE;

  // effective data address of a byte-oriented operand
  always_comb begin
    if (dec_q.access) begin
      eff_addr = {bank_q, dec_q.file};
    end else if (ext_en_q && dec_q.file <= exec_pkg::INDEX_LIMIT) begin
      eff_addr = {ptr_hi_q[exec_pkg::INDEX_PTR],
                  ptr_lo_q[exec_pkg::INDEX_PTR]} +
                 {4'h0, dec_q.file};
    end else if (dec_q.file < exec_pkg::ACCESS_SPLIT) begin
      eff_addr = {exec_pkg::ACCESS_LO_BANK, dec_q.file};
    end else begin
      eff_addr = {exec_pkg::ACCESS_HI_BANK, dec_q.file};
    end
  end

  // memory port: execution owns it while busy, apb otherwise
  always_comb begin
    mem_req = '0;
    if (busy) begin
      if (ex_state_q == exec_pkg::EX_Q2 && !cycle_q) begin
        mem_req.rd   = file_op || dec_q.kind == exec_pkg::OP_REG_MOVE;
        mem_req.addr = file_op ? eff_addr : dec_q.src;
      end else if (q4_first && file_op && dec_q.dest) begin
        mem_req.wr    = 1'b1;
        mem_req.addr  = eff_addr;
        mem_req.wdata = result_q;
      end else if (q4_second && word2_ok_q &&
                   dec_q.kind == exec_pkg::OP_REG_MOVE) begin
        mem_req.wr    = 1'b1;
        mem_req.addr  = instr_q[27:16];
        mem_req.wdata = result_q;
      end
    end else if (mem_rd_req) begin
      mem_req.rd   = 1'b1;
      mem_req.addr = mem_addr_q;
    end else if (apb_wr && paddr_in == exec_pkg::MEM_DATA_OFS) begin
      mem_req.wr    = 1'b1;
      mem_req.addr  = mem_addr_q;
      mem_req.wdata = pwdata_in[7:0];
    end
  end

  data_ram #(
    .DATA_W (8),
    .ADDR_W (ADDR_W)
  ) u_data_ram (
    .clk_sys_in  (clk_sys_in),
    .rd_en_in    (mem_req.rd),
    .wr_en_in    (mem_req.wr),
    .addr_in     (mem_req.addr),
    .wr_data_in  (mem_req.wdata),
    .rd_data_out (mem_rd_data)
  );

  // register read mux and refusal decode
  always_comb begin
    rd_val = '0;
    refuse = busy && pwrite_in;
    unique case (paddr_in)
      exec_pkg::CTRL_OFS: begin
        rd_val[exec_pkg::CTRL_EXT_BIT] = ext_en_q;
        refuse = 1'b0;
      end
      exec_pkg::INSTR_OFS: rd_val = instr_q;
      exec_pkg::ACC_OFS: rd_val[7:0] = acc_q;
      exec_pkg::BANK_OFS: rd_val[3:0] = bank_q;
      exec_pkg::PTR0_OFS: rd_val[11:0] = {ptr_hi_q[0], ptr_lo_q[0]};
      exec_pkg::PTR1_OFS: rd_val[11:0] = {ptr_hi_q[1], ptr_lo_q[1]};
      exec_pkg::PTR2_OFS: rd_val[11:0] = {ptr_hi_q[2], ptr_lo_q[2]};
      exec_pkg::STATUS_OFS: begin
        refuse = 1'b0;
        rd_val[exec_pkg::STAT_BUSY_BIT]    = busy;
        rd_val[exec_pkg::STAT_ZERO_BIT]    = zero_q;
        rd_val[exec_pkg::STAT_NEG_BIT]     = neg_q;
        rd_val[exec_pkg::STAT_ILLEGAL_BIT] = illegal_q;
      end
      exec_pkg::MEM_ADDR_OFS: rd_val[ADDR_W-1:0] = mem_addr_q;
      exec_pkg::MEM_DATA_OFS: refuse = busy;
      default: refuse = 1'b1;
    endcase
  end

  // apb handshake: one wait cycle, two for a memory read
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      prdata_q  <= exec_pkg::WORD_RST;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      wait_q    <= 1'b0;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      if (access && wait_q) begin
        pready_q <= 1'b1;
        prdata_q <= {24'h000000, mem_rd_data};
        wait_q   <= 1'b0;
      end else if (mem_rd_req) begin
        wait_q <= 1'b1;
      end else if (access) begin
        pready_q  <= 1'b1;
        pslverr_q <= refuse;
        prdata_q  <= (refuse || pwrite_in) ? exec_pkg::WORD_RST : rd_val;
      end
    end
  end

  // control and memory address registers
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      ext_en_q   <= 1'b0;
      mem_addr_q <= exec_pkg::MADR_RST;
    end else if (apb_wr) begin
      if (paddr_in == exec_pkg::CTRL_OFS) begin
        ext_en_q <= pwdata_in[exec_pkg::CTRL_EXT_BIT];
      end
      if (paddr_in == exec_pkg::MEM_ADDR_OFS) begin
        mem_addr_q <= pwdata_in[ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      bank_q <= exec_pkg::BANK_RST;
    end else if (apb_wr && paddr_in == exec_pkg::BANK_OFS) begin
      bank_q <= pwdata_in[3:0];
    end
  end

  // quarter-cycle sequencer
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      ex_state_q <= exec_pkg::EX_IDLE;
      instr_q    <= exec_pkg::WORD_RST;
      cycle_q    <= 1'b0;
      word2_ok_q <= 1'b0;
      result_q   <= exec_pkg::ACC_RST;
      dec_q      <= '0;
    end else begin
      unique case (ex_state_q)
        exec_pkg::EX_IDLE: begin
          if (apb_wr && paddr_in == exec_pkg::INSTR_OFS) begin
            instr_q    <= pwdata_in;
            cycle_q    <= 1'b0;
            ex_state_q <= exec_pkg::EX_Q1;
          end
        end
        exec_pkg::EX_Q1: begin
          if (!cycle_q) begin
            dec_q <= decode_word(instr_q[15:0]);
          end else if (dec_q.kind == exec_pkg::OP_PTR_LOAD) begin
            word2_ok_q <= instr_q[31:24] == exec_pkg::PTR_LOAD_W2;
          end else begin
            word2_ok_q <= instr_q[31:28] == exec_pkg::REG_MOVE_W2;
          end
          ex_state_q <= exec_pkg::EX_Q2;
        end
        exec_pkg::EX_Q2: ex_state_q <= exec_pkg::EX_Q3;
        exec_pkg::EX_Q3: begin
          if (!cycle_q) begin
            unique case (dec_q.kind)
              exec_pkg::OP_IOR_LIT:   result_q <= acc_q | dec_q.file;
              exec_pkg::OP_IOR_FILE:  result_q <= acc_q | mem_rd_data;
              exec_pkg::OP_FILE_MOVE: result_q <= mem_rd_data;
              exec_pkg::OP_REG_MOVE:  result_q <= mem_rd_data;
              default:                result_q <= result_q;
            endcase
          end
          ex_state_q <= exec_pkg::EX_Q4;
        end
        exec_pkg::EX_Q4: begin
          if (!cycle_q && (dec_q.kind == exec_pkg::OP_PTR_LOAD ||
                           dec_q.kind == exec_pkg::OP_REG_MOVE)) begin
            cycle_q    <= 1'b1;
            ex_state_q <= exec_pkg::EX_Q1;
          end else begin
            ex_state_q <= exec_pkg::EX_IDLE;
          end
        end
      endcase
    end
  end

  // accumulator and flags
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      acc_q  <= exec_pkg::ACC_RST;
      zero_q <= 1'b0;
      neg_q  <= 1'b0;
    end else if (q4_first && (dec_q.kind == exec_pkg::OP_IOR_LIT ||
                              file_op)) begin
      if (dec_q.kind == exec_pkg::OP_IOR_LIT || !dec_q.dest) begin
        acc_q <= result_q;
      end
      zero_q <= result_q == 8'h00;
      neg_q  <= result_q[7];
    end else if (apb_wr && paddr_in == exec_pkg::ACC_OFS) begin
      acc_q <= pwdata_in[7:0];
    end
  end

  // file select pointers
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      ptr_hi_q <= '{3{exec_pkg::PTR_RST[11:8]}};
      ptr_lo_q <= '{3{exec_pkg::PTR_RST[7:0]}};
    end else if (dec_q.kind == exec_pkg::OP_PTR_LOAD && q4_first) begin
      ptr_hi_q[dec_q.sel] <= dec_q.lit_hi;
    end else if (dec_q.kind == exec_pkg::OP_PTR_LOAD && q4_second &&
                 word2_ok_q) begin
      ptr_lo_q[dec_q.sel] <= instr_q[23:16];
    end else if (apb_wr) begin
      for (int i = 0; i < 3; i++) begin
        if (paddr_in == exec_pkg::PTR0_OFS + 8'(4 * i)) begin
          ptr_hi_q[i] <= pwdata_in[11:8];
          ptr_lo_q[i] <= pwdata_in[7:0];
        end
      end
    end
  end

  // sticky illegal flag; a new event wins over a clear
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      illegal_q <= 1'b0;
    end else if ((q4_first && dec_q.kind == exec_pkg::OP_NONE) ||
                 (q4_second && !word2_ok_q)) begin
      illegal_q <= 1'b1;
    end else if (apb_wr && paddr_in == exec_pkg::STATUS_OFS &&
                 pwdata_in[exec_pkg::STAT_ILLEGAL_BIT]) begin
      illegal_q <= 1'b0;
    end
  end

endmodule

//--- hw/exec_pkg.sv
// constants and types shared by the instruction execution unit
// assumes a 32-bit apb slave port and a 4096-byte data memory
package exec_pkg;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] INSTR_OFS    = 8'h04;
  localparam logic [7:0] ACC_OFS      = 8'h08;
  localparam logic [7:0] BANK_OFS     = 8'h0c;
  localparam logic [7:0] PTR0_OFS     = 8'h10;
  localparam logic [7:0] PTR1_OFS     = 8'h14;
  localparam logic [7:0] PTR2_OFS     = 8'h18;
  localparam logic [7:0] STATUS_OFS   = 8'h1c;
  localparam logic [7:0] MEM_ADDR_OFS = 8'h20;
  localparam logic [7:0] MEM_DATA_OFS = 8'h24;

  // field positions
  localparam int CTRL_EXT_BIT    = 0;
  localparam int STAT_BUSY_BIT   = 1 - 1;
  localparam int STAT_ZERO_BIT   = 1;
  localparam int STAT_NEG_BIT    = 2;
  localparam int STAT_ILLEGAL_BIT = 3;

  // values after reset
  localparam logic [7:0]  ACC_RST  = 8'h00;
  localparam logic [3:0]  BANK_RST = 4'h0;
  localparam logic [11:0] PTR_RST  = 12'h000;
  localparam logic [11:0] MADR_RST = 12'h000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // opcode patterns of the first word
  localparam logic [7:0] IOR_LIT_OP   = 8'h09;
  localparam logic [5:0] IOR_FILE_OP  = 6'h04;
  localparam logic [5:0] FILE_MOVE_OP = 6'h14;
  localparam logic [9:0] PTR_LOAD_OP  = 10'h3b8;
  localparam logic [3:0] REG_MOVE_OP  = 4'hc;
  // opcode patterns of the second word
  localparam logic [7:0] PTR_LOAD_W2  = 8'hf0;
  localparam logic [3:0] REG_MOVE_W2  = 4'hf;

  // addressing
  localparam logic [1:0] PTR_SEL_BAD   = 2'd3;
  localparam logic [1:0] INDEX_PTR     = 2'd2;
  localparam logic [7:0] INDEX_LIMIT   = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT  = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_IOR_LIT,
    OP_IOR_FILE,
    OP_PTR_LOAD,
    OP_FILE_MOVE,
    OP_REG_MOVE
  } op_kind_t;

  typedef enum logic [2:0] {
    EX_IDLE,
    EX_Q1,
    EX_Q2,
    EX_Q3,
    EX_Q4
  } ex_state_t;

  // decoded first instruction word
  typedef struct packed {
    op_kind_t    kind;
    logic        dest;
    logic        access;
    logic [7:0]  file;
    logic [1:0]  sel;
    logic [3:0]  lit_hi;
    logic [11:0] src;
  } decode_t;

  // one data memory request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } mem_req_t;

endpackage

//--- hw/data_ram.sv
// single-port data memory with registered read data
// assumes one request per cycle; read data appear the cycle after rd_en
`timescale 1ns/100ps
module data_ram #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rd_en_in,
  input  wire logic              wr_en_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  output logic      [DATA_W-1:0] rd_data_out
);

  logic [DATA_W-1:0] mem_q [2**ADDR_W];
  logic [DATA_W-1:0] rd_data_q;

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem_q[addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rd_en_in) begin
      rd_data_q <= mem_q[addr_in];
    end
  end

  assign rd_data_out = rd_data_q;

endmodule

//--- testbench/exec_apb_chk.sv
// apb timing and response checks for the instruction execution unit
// assumes it is bound to or_move_load_instr_exec and sees only its ports
`timescale 1ns/100ps
module exec_apb_chk (
  input wire logic        clk_sys_in,
  input wire logic        reset_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  logic acc_ph;
  logic md;
  assign acc_ph = psel_in && penable_in && !pready_out;
  assign md     = paddr_in == exec_pkg::MEM_DATA_OFS;

  a_reg_one_wait: assert property (
    acc_ph && !md |=> pready_out) else $error("register answer late");
  a_mem_two_wait: assert property (
    $rose(penable_in) && psel_in && md && !pwrite_in |=>
    (pready_out && pslverr_out) or (!pready_out ##1 pready_out))
    else $error("memory answer timing");
  a_ready_pulse: assert property (
    pready_out |=> !pready_out) else $error("ready held too long");
  a_ready_in_access: assert property (
    pready_out |-> psel_in && penable_in) else $error("ready outside access");
  a_err_with_ready: assert property (
    pslverr_out |-> pready_out) else $error("error without ready");
  a_unaligned_err: assert property (
    pready_out && paddr_in[1:0] != 2'h0 |-> pslverr_out)
    else $error("unaligned not refused");
  a_high_addr_err: assert property (
    pready_out && paddr_in > exec_pkg::MEM_DATA_OFS |-> pslverr_out)
    else $error("unmapped not refused");
  a_err_data_zero: assert property (
    pslverr_out |-> prdata_out == 32'h0) else $error("error data not zero");
  a_write_data_zero: assert property (
    pready_out && pwrite_in |-> prdata_out == 32'h0)
    else $error("write data not zero");
  a_acc_upper_zero: assert property (
    pready_out && !pwrite_in && paddr_in == exec_pkg::ACC_OFS
    |-> prdata_out[31:8] == 24'h0) else $error("accumulator upper bits");

  c_instr_wr: cover property (pready_out && pwrite_in && !md);
  c_refused: cover property (pslverr_out);
  c_mem_rd: cover property (pready_out && md && !pwrite_in);
endmodule

bind or_move_load_instr_exec exec_apb_chk chk_i (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out));

//--- testbench/testbench.sv
// self-checking bench for the instruction execution unit
// assumes an apb master driven here at 20 mhz and the exec_pkg map
`timescale 1ns/100ps
module testbench;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] v;
  logic        e;
  int          fail_count = 0;
  int          tests_run = 0;

  always #25 clk_sys = ~clk_sys;

  or_move_load_instr_exec dut (.clk_sys_in(clk_sys), .reset_n_in(reset_n),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr));

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // one apb transfer; releases the bus and idles one cycle after it
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(v, x);
  endtask

  task automatic idle_wait();
    do begin
      xfer(1'b0, exec_pkg::STATUS_OFS, 32'h0);
    end while (v[0] !== 1'b0);
  endtask

  task automatic run(input logic [31:0] op);
    wr(exec_pkg::INSTR_OFS, op);
    idle_wait();
  endtask

  task automatic poke(input logic [11:0] a, input logic [7:0] d);
    wr(exec_pkg::MEM_ADDR_OFS, {20'h0, a});
    wr(exec_pkg::MEM_DATA_OFS, {24'h0, d});
  endtask

  task automatic peek(input logic [11:0] a, input logic [7:0] x);
    wr(exec_pkg::MEM_ADDR_OFS, {20'h0, a});
    rd(exec_pkg::MEM_DATA_OFS, {24'h0, x});
  endtask

  task automatic t_reset();
    for (int a = 0; a <= 32; a += 4) begin
      rd(8'(a), 32'h0);
    end
    $display("reset values done");
  endtask

  task automatic t_or();
    wr(exec_pkg::ACC_OFS, 32'h9a);
    run(32'h0935);
    rd(exec_pkg::ACC_OFS, 32'hbf);
    rd(exec_pkg::STATUS_OFS, 32'h4);
    wr(exec_pkg::BANK_OFS, 32'h3);
    poke(12'h345, 8'h13);
    wr(exec_pkg::ACC_OFS, 32'h91);
    run(32'h1145);
    rd(exec_pkg::ACC_OFS, 32'h93);
    wr(exec_pkg::ACC_OFS, 32'h04);
    run(32'h1345);
    peek(12'h345, 8'h17);
    rd(exec_pkg::ACC_OFS, 32'h04);
    $display("or tests done");
  endtask

  task automatic t_move();
    poke(12'hfff, 8'h00);
    wr(exec_pkg::ACC_OFS, 32'h55);
    run(32'h50ff);
    rd(exec_pkg::ACC_OFS, 32'h00);
    rd(exec_pkg::STATUS_OFS, 32'h2);
    poke(12'h020, 8'h40);
    wr(exec_pkg::ACC_OFS, 32'h01);
    run(32'h1020);
    rd(exec_pkg::ACC_OFS, 32'h41);
    wr(exec_pkg::CTRL_OFS, 32'h1);
    wr(exec_pkg::PTR2_OFS, 32'h123);
    run(32'h5145);
    rd(exec_pkg::ACC_OFS, 32'h17);
    wr(exec_pkg::ACC_OFS, 32'h00);
    run(32'h5345);
    peek(12'h345, 8'h17);
    rd(exec_pkg::ACC_OFS, 32'h00);
    poke(12'h182, 8'ha5);
    run(32'h505f);
    rd(exec_pkg::ACC_OFS, 32'ha5);
    wr(exec_pkg::CTRL_OFS, 32'h0);
    poke(12'h033, 8'h33);
    poke(12'habc, 8'h11);
    run(32'hfabc_c033);
    peek(12'habc, 8'h33);
    rd(exec_pkg::STATUS_OFS, 32'h4);
    $display("move tests done");
  endtask

  task automatic t_load();
    for (int s = 0; s < 3; s++) begin
      wr(8'(16 + 4 * s), 32'h0);
      wr(exec_pkg::INSTR_OFS, 32'hf0ab_ee03 | (s << 4));
      repeat (3) @(posedge clk_sys);
      rd(8'(16 + 4 * s), 32'h300);
      idle_wait();
      rd(8'(16 + 4 * s), 32'h3ab);
      rd(exec_pkg::STATUS_OFS, 32'h4);
    end
    run(32'hf000_ee30);
    rd(exec_pkg::STATUS_OFS, 32'hc);
    wr(exec_pkg::STATUS_OFS, 32'h8);
    rd(exec_pkg::STATUS_OFS, 32'h4);
    run(32'he0ab_ee05);
    rd(exec_pkg::PTR0_OFS, 32'h5ab);
    rd(exec_pkg::STATUS_OFS, 32'hc);
    $display("pointer load done");
  endtask

  task automatic t_refuse();
    wr(exec_pkg::INSTR_OFS, 32'hf000_ee00);
    xfer(1'b1, exec_pkg::ACC_OFS, 32'h77);
    chk({31'h0, e}, 32'h1);
    idle_wait();
    rd(exec_pkg::ACC_OFS, 32'ha5);
    xfer(1'b0, 8'h28, 32'h0);
    chk({31'h0, e}, 32'h1);
    xfer(1'b0, 8'h02, 32'h0);
    chk({e, v[30:0]}, 32'h8000_0000);
    $display("refusal done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_or();
    t_move();
    t_load();
    t_refuse();
    final_report();
  end
endmodule
